/* File: rtl/dsb_pkg.sv */
// Shared constants, carrier structs and state types of the DRAM strobe and
// byte-lane output stage.
// Assumes a single 200 MHz clock and an APB3 register port.
package dsb_pkg;

  // ------------------------------------------------------------------------
  // Register map and field positions
  // ------------------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;  // Control bits
  localparam logic [7:0] STAT_OFS = 8'h04;  // Live state, read only
  localparam logic [7:0] BANK0_OFS = 8'h10; // Bank regions at 10,14,18,1C
  localparam int CTRL_EN_BIT = 0;           // Controller enable
  localparam int CTRL_EDO_BIT = 1;          // EDO memory attached
  localparam int CTRL_TWO_WE_BIT = 2;       // 2-WE byte control
  localparam int CTRL_BUS16_BIT = 3;        // 16-bit data bus
  localparam int CTRL_BURST_BIT = 4;        // Burst enable
  localparam int BANK_BASE_LSB = 20;        // Base match field [31:20]
  localparam int BANK_MASK_LSB = 4;         // Compare mask field [15:4]
  localparam int BANK_VALID_BIT = 0;        // Region valid
  localparam logic [4:0] CTRL_RST = 5'h00;  // Controller off after reset

  // ------------------------------------------------------------------------
  // Sizes and timing
  // ------------------------------------------------------------------------
  localparam int MUX_W = 12;                // Address pins 13:2
  localparam int ROW_LSB = 14;              // Row taken from access addr
  localparam logic [1:0] BURST_LAST = 2'h3; // Four beats per burst

  // ------------------------------------------------------------------------
  // Carrier types
  // ------------------------------------------------------------------------
  typedef struct packed {
    logic burst;
    logic bus16;
    logic two_we;
    logic edo;
    logic en;
  } dsb_cfg_t;

  typedef struct packed {
    logic [11:0] base;
    logic [11:0] mask;
    logic valid;
  } dsb_bank_t;

  typedef struct packed {
    logic [3:0] row_n;
    logic [3:0] col_n;
    logic [3:0] we_n;
    logic oe_n;
  } dsb_strobe_t;

  localparam dsb_strobe_t STROBE_IDLE = '{4'hF, 4'hF, 4'hF, 1'b1};

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ROW = 3'b001,
    ST_COL = 3'b010,
    ST_CPRE = 3'b011,
    ST_PRE = 3'b100
  } dsb_state_t;

  typedef struct packed {
    dsb_state_t state;
    logic [1:0] bank;
    logic write;
    logic [3:0] col_m;
    logic [3:0] we_m;
    logic [MUX_W-1:0] col_addr;
    logic [1:0] beat;
    dsb_strobe_t stb;
    logic [MUX_W-1:0] addr_out;
    logic addr_oe_n;
    logic burst_n;
    logic [1:0] rdy_s;
  } dsb_core_t;

  typedef struct packed {
    logic [4:0] ctrl;
    dsb_bank_t [3:0] bank;
    logic [31:0] rdata;
    logic err;
  } dsb_regs_t;

endpackage : dsb_pkg

/* File: rtl/dsb_apb_regs.sv */
// APB3 register slave: control bits, four bank regions and a status word.
// Assumes the APB master runs on core_clk_in; zero wait states.
`timescale 1ns/1ps
module dsb_apb_regs (
  input wire logic core_clk_in,             // Bus clock
  input wire logic sys_rst_in,              // Synchronous reset, high
  input wire logic [7:0] paddr_in,          // APB byte address
  input wire logic psel_in,                 // APB select
  input wire logic penable_in,              // APB access phase
  input wire logic pwrite_in,               // APB direction
  input wire logic [31:0] pwdata_in,        // APB write data
  input wire logic [7:0] status_in,         // Core state for status reg
  output logic [31:0] prdata_out,           // APB read data
  output logic pready_out,                  // APB ready
  output logic pslverr_out,                 // APB error, unmapped addr
  output dsb_pkg::dsb_cfg_t cfg_out,        // Control bits to core
  output dsb_pkg::dsb_bank_t [3:0] bank_out // Bank regions to core
);

  // ------------------------------------------------------------------------
  // Address decode: 0 ctrl, 1 status, 2..5 banks, 7 unmapped
  // ------------------------------------------------------------------------
  function automatic logic [2:0] reg_sel(input logic [7:0] a);
    logic [2:0] r;
    r = 3'h7;
    if (a == dsb_pkg::CTRL_OFS) r = 3'h0;
    else if (a == dsb_pkg::STAT_OFS) r = 3'h1;
    else if (a[7:4] == dsb_pkg::BANK0_OFS[7:4] && a[1:0] == 2'h0)
      r = 3'(a[3:2]) + 3'h2;
    return r;
  endfunction : reg_sel

  dsb_pkg::dsb_regs_t cur;                  // Registered state
  dsb_pkg::dsb_regs_t next_cur;             // Next state
  logic [2:0] sel;                          // Decoded register

  assign sel = reg_sel(paddr_in);

  // Read data is captured in the setup cycle, writes land in access phase
  always_comb begin
    next_cur = cur;
    if (psel_in && !penable_in) begin
      next_cur.err = (sel == 3'h7);
      unique case (sel)
        3'h0: next_cur.rdata = {27'h0, cur.ctrl};
        3'h1: next_cur.rdata = {24'h0, status_in};
        3'h7: next_cur.rdata = 32'h0;
        default: begin
          next_cur.rdata = 32'h0;
          next_cur.rdata[31:20] = cur.bank[sel-3'h2].base;
          next_cur.rdata[15:4] = cur.bank[sel-3'h2].mask;
          next_cur.rdata[0] = cur.bank[sel-3'h2].valid;
        end
      endcase
    end
    if (psel_in && penable_in && pwrite_in) begin
      if (sel == 3'h0) begin
        next_cur.ctrl = pwdata_in[4:0];
      end else if (sel >= 3'h2 && sel <= 3'h5) begin
        next_cur.bank[sel-3'h2].base = pwdata_in[31:20];
        next_cur.bank[sel-3'h2].mask = pwdata_in[15:4];
        next_cur.bank[sel-3'h2].valid = pwdata_in[0];
      end
    end
  end

  // State register
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      next_cur_rst: begin
        cur <= '0;
        cur.ctrl <= dsb_pkg::CTRL_RST;
      end
    end else begin
      cur <= next_cur;
    end
  end

  assign prdata_out = cur.rdata;
  assign pready_out = 1'b1;
  assign pslverr_out = cur.err;
  assign cfg_out = dsb_pkg::dsb_cfg_t'(cur.ctrl);
  assign bank_out = cur.bank;

endmodule : dsb_apb_regs

/* File: rtl/dsb_strobe_lane.sv */
// DRAM strobe and byte-lane output stage: bank decode, row/column strobe
// sequencing, byte-lane strobes and the multiplexed address pins 13:2.
// Assumes access request signals come from same-clock bus logic; the
// ready pin is asynchronous and is synchronised here.
//
// Operation
// RULE1: One active-low row strobe per bank 0-3
// RULE2: 32-bit 2-CAS: column strobes follow byte lanes
// RULE3: 16-bit 2-CAS: lane2 even, lane3 odd byte
// RULE4: 2-WE: all column strobes share one waveform
// RULE5: 2-WE: write strobes select written byte lanes
// RULE6: 2-CAS: all write strobes share one waveform
// RULE7: Fast-page: early write, output enable unused
// RULE8: EDO: output enable low only while reading
// RULE9: Row then column address on pins 13:2
// RULE10: Drive pins cycle after strobe until ready
// RULE11: Controller disabled: address pins stay released; the code drives them while reset is held
// RULE12: Reset holds all strobes high
// RULE13: Strobes stay actively driven during bus grant
// RULE14: Burst request answered by internal controller
// RULE15: Bank chosen by decoding configured regions
// RULE16: Row strobe precedes column strobe each access
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ps
module dsb_strobe_lane (
  input wire logic core_clk_in,             // Bus clock, 200 MHz
  input wire logic sys_rst_in,              // Synchronous reset, high
  input wire logic [7:0] paddr_in,          // APB address
  input wire logic psel_in,                 // APB select
  input wire logic penable_in,              // APB enable
  input wire logic pwrite_in,               // APB direction
  input wire logic [31:0] pwdata_in,        // APB write data
  output logic [31:0] prdata_out,           // APB read data
  output logic pready_out,                  // APB ready
  output logic pslverr_out,                 // APB error
  input wire logic address_strobe_n_in,     // Access start, low
  input wire logic [31:0] access_addr_in,   // Access byte address
  input wire logic access_write_in,         // Access is a write
  input wire logic [3:0] access_be_in,      // Lane enables, 0 = b31-b24
  input wire logic ready_n_in,              // Beat ready pin, low
  output logic row_strobe_bank0_n_out,      // Bank 0 row strobe
  output logic row_strobe_bank1_n_out,      // Bank 1 row strobe
  output logic row_strobe_bank2_n_out,      // Bank 2 row strobe
  output logic row_strobe_bank3_n_out,      // Bank 3 row strobe
  output logic column_strobe_lane0_n_out,   // Lane 0 column strobe
  output logic column_strobe_lane1_n_out,   // Lane 1 column strobe
  output logic column_strobe_lane2_n_out,   // Lane 2 column strobe
  output logic column_strobe_lane3_n_out,   // Lane 3 column strobe
  output logic mem_write_strobe_lane0_n_out, // Lane 0 write strobe
  output logic mem_write_strobe_lane1_n_out, // Lane 1 write strobe
  output logic mem_write_strobe_lane2_n_out, // Lane 2 write strobe
  output logic mem_write_strobe_lane3_n_out, // Lane 3 write strobe
  output logic mem_output_enable_n_out,     // Memory output enable
  output logic burst_request_n_out,         // Burst request, low
  output logic [11:0] addr_pin_out,         // Address pins 13:2 value
  output logic addr_pin_oe_n_out            // Low while pins are driven
);

  // ------------------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------------------
  // Lowest matching valid bank wins; bit 2 flags a hit
  function automatic logic [2:0] bank_hit(
    input logic [31:0] a,
    input dsb_pkg::dsb_bank_t [3:0] b
  );
    logic [2:0] r;
    r = 3'h0;
    for (int i = 3; i >= 0; i--) begin
      if (b[i].valid && ((a[31:20] ^ b[i].base) & b[i].mask) == 12'h000)
        r = {1'b1, 2'(i)};
    end
    return r;
  endfunction : bank_hit

  // Lane mask: a 16-bit bus uses lanes 2 (even) and 3 (odd) only
  function automatic logic [3:0] lane_map(
    input logic [3:0] be,
    input logic bus16
  );
    return bus16 ? {be[3], be[2], 2'b00} : be;
  endfunction : lane_map

  // ------------------------------------------------------------------------
  // Register slave
  // ------------------------------------------------------------------------
  dsb_pkg::dsb_cfg_t cfg;                   // Control bits
  dsb_pkg::dsb_bank_t [3:0] bank;           // Bank regions
  dsb_pkg::dsb_core_t cur;                  // Registered core state
  dsb_pkg::dsb_core_t next_cur;             // Next core state
  logic [7:0] status;                       // Live state to software

  assign status = {cfg.en, ~cur.burst_n, cur.beat, cur.bank,
                   cur.state[2:1]};

  dsb_apb_regs u_regs (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .paddr_in(paddr_in),
    .psel_in(psel_in),
    .penable_in(penable_in),
    .pwrite_in(pwrite_in),
    .pwdata_in(pwdata_in),
    .status_in(status),
    .prdata_out(prdata_out),
    .pready_out(pready_out),
    .pslverr_out(pslverr_out),
    .cfg_out(cfg),
    .bank_out(bank)
  );

  // ------------------------------------------------------------------------
  // Access decode
  // ------------------------------------------------------------------------
  logic [2:0] hit;                          // Bank decode result
  logic start;                              // Access begins this cycle
  logic [3:0] lanes;                        // Lanes touched by access
  logic [3:0] col_mask;                     // Column strobes to assert
  logic [3:0] we_mask;                      // Write strobes to assert
  logic rdy_low;                            // Synchronised ready low

  assign hit = bank_hit(access_addr_in, bank); // RULE15
  assign start = !address_strobe_n_in && cfg.en && hit[2]; // RULE11
  assign lanes = lane_map(access_be_in, cfg.bus16); // RULE2 RULE3
  // 2-WE shares one column waveform, 2-CAS selects by column strobe
  assign col_mask = cfg.two_we ? {4{|lanes}} : lanes; // RULE4
  // 2-WE selects lanes by write strobe, 2-CAS shares one waveform
  assign we_mask = !access_write_in ? 4'h0 :
                   (cfg.two_we ? lanes : 4'hF); // RULE5 RULE6
  assign rdy_low = !cur.rdy_s[1];

  // ------------------------------------------------------------------------
  // Access sequencer
  // ------------------------------------------------------------------------
  // Row phase, column phase(s), then one precharge cycle
  always_comb begin
    next_cur = cur;
    next_cur.rdy_s = {cur.rdy_s[0], ready_n_in};
    unique case (cur.state)
      dsb_pkg::ST_IDLE: begin
        // Strobes idle high, pins released
        next_cur.stb = dsb_pkg::STROBE_IDLE;
        next_cur.addr_oe_n = 1'b1;
        next_cur.burst_n = 1'b1;
        if (start) begin
          next_cur.state = dsb_pkg::ST_ROW;
          next_cur.bank = hit[1:0];
          next_cur.write = access_write_in;
          next_cur.col_m = col_mask;
          next_cur.we_m = we_mask;
          next_cur.col_addr = access_addr_in[13:2];
          next_cur.beat = 2'h0;
          // Row address goes out with the row strobe
          next_cur.addr_out =
            access_addr_in[dsb_pkg::ROW_LSB +: dsb_pkg::MUX_W]; // RULE9
          next_cur.addr_oe_n = 1'b0; // RULE10
          next_cur.stb.row_n = ~(4'h1 << hit[1:0]); // RULE1
          // Write strobes lead the column strobe: early write
          next_cur.stb.we_n = ~we_mask; // RULE7
          next_cur.burst_n = ~cfg.burst; // RULE14
        end
      end
      dsb_pkg::ST_ROW: begin
        // Column address and column strobe follow the row phase
        next_cur.state = dsb_pkg::ST_COL;
        next_cur.addr_out = cur.col_addr; // RULE9
        next_cur.stb.col_n = ~cur.col_m; // RULE16
        next_cur.stb.oe_n = ~(cfg.edo && !cur.write); // RULE8
      end
      dsb_pkg::ST_COL: begin
        if (rdy_low) begin
          if (!cur.burst_n && cur.beat != dsb_pkg::BURST_LAST) begin
            // Internal burst answer: page-mode next column
            next_cur.state = dsb_pkg::ST_CPRE; // RULE14
            next_cur.stb.col_n = 4'hF;
            next_cur.beat = cur.beat + 2'h1;
            next_cur.col_addr = cur.col_addr + 12'h001;
            next_cur.addr_out = cur.col_addr + 12'h001;
          end else begin
            // Ready ends the access and releases the pins
            next_cur.state = dsb_pkg::ST_PRE;
            next_cur.stb = dsb_pkg::STROBE_IDLE;
            next_cur.addr_oe_n = 1'b1; // RULE10
            next_cur.burst_n = 1'b1;
          end
        end
      end
      dsb_pkg::ST_CPRE: begin
        // Wait for ready to rise before the next beat
        if (!rdy_low) begin
          next_cur.state = dsb_pkg::ST_COL;
          next_cur.stb.col_n = ~cur.col_m;
        end
      end
      dsb_pkg::ST_PRE: begin
        // One row precharge cycle
        next_cur.state = dsb_pkg::ST_IDLE;
      end
      default: begin
        // Illegal code: return to idle with strobes high
        next_cur.state = dsb_pkg::ST_IDLE;
        next_cur.stb = dsb_pkg::STROBE_IDLE;
        next_cur.addr_oe_n = 1'b1;
        next_cur.burst_n = 1'b1;
      end
    endcase
  end

  // State register; reset forces strobes high and drives the pins
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      cur <= '0;
      cur.stb <= dsb_pkg::STROBE_IDLE; // RULE12
      cur.burst_n <= 1'b1;
      cur.rdy_s <= 2'b11;
      cur.addr_oe_n <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  // ------------------------------------------------------------------------
  // Pin outputs
  // ------------------------------------------------------------------------
  // Strobes have no enable and are driven in every bus state
  assign row_strobe_bank0_n_out = cur.stb.row_n[0]; // RULE13
  assign row_strobe_bank1_n_out = cur.stb.row_n[1];
  assign row_strobe_bank2_n_out = cur.stb.row_n[2];
  assign row_strobe_bank3_n_out = cur.stb.row_n[3];
  assign column_strobe_lane0_n_out = cur.stb.col_n[0];
  assign column_strobe_lane1_n_out = cur.stb.col_n[1];
  assign column_strobe_lane2_n_out = cur.stb.col_n[2];
  assign column_strobe_lane3_n_out = cur.stb.col_n[3];
  assign mem_write_strobe_lane0_n_out = cur.stb.we_n[0];
  assign mem_write_strobe_lane1_n_out = cur.stb.we_n[1];
  assign mem_write_strobe_lane2_n_out = cur.stb.we_n[2];
  assign mem_write_strobe_lane3_n_out = cur.stb.we_n[3];
  assign mem_output_enable_n_out = cur.stb.oe_n;
  assign burst_request_n_out = cur.burst_n;
  assign addr_pin_out = cur.addr_out;
  assign addr_pin_oe_n_out = cur.addr_oe_n;

  // ------------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------------
  logic busy;                               // Row strobe phase active
  assign busy = cur.state != dsb_pkg::ST_IDLE &&
                cur.state != dsb_pkg::ST_PRE;

  a_reset_strobes: assert property (@(posedge core_clk_in) // RULE12
    sys_rst_in |=> (cur.stb.row_n == 4'hF && cur.stb.col_n == 4'hF &&
                    cur.stb.oe_n))
    else $error("strobe low after reset");
  a_row_bank: assert property (@(posedge core_clk_in) // RULE1
    disable iff (sys_rst_in)
    ~cur.stb.row_n == (busy ? (4'h1 << cur.bank) : 4'h0))
    else $error("row strobe not matching bank");
  a_row_first: assert property (@(posedge core_clk_in) // RULE16
    disable iff (sys_rst_in)
    (cur.stb.col_n != 4'hF) |-> $past(cur.stb.row_n != 4'hF))
    else $error("column strobe without prior row strobe");
  a_two_we_cas: assert property (@(posedge core_clk_in) // RULE4
    disable iff (sys_rst_in)
    cfg.two_we |-> (cur.stb.col_n == 4'hF || cur.stb.col_n == 4'h0))
    else $error("column strobes differ in 2-WE mode");
  a_two_cas_we: assert property (@(posedge core_clk_in) // RULE6
    disable iff (sys_rst_in)
    !cfg.two_we && start |=> (cur.stb.we_n == 4'hF ||
                              cur.stb.we_n == 4'h0))
    else $error("write strobes differ in 2-CAS mode");
  a_early_write: assert property (@(posedge core_clk_in) // RULE7
    disable iff (sys_rst_in)
    start && access_write_in |=> (cur.stb.we_n != 4'hF) ##1
      (cur.stb.we_n != 4'hF && cur.stb.col_n != 4'hF))
    else $error("write strobe not ahead of column strobe");
  a_oe_edo: assert property (@(posedge core_clk_in) // RULE8
    disable iff (sys_rst_in)
    !cur.stb.oe_n |-> (cfg.edo && !cur.write && busy))
    else $error("output enable low outside an EDO read");
  a_addr_drive: assert property (@(posedge core_clk_in) // RULE10
    disable iff (sys_rst_in)
    start |=> (!addr_pin_oe_n_out && addr_pin_out ==
               $past(access_addr_in[dsb_pkg::ROW_LSB +: dsb_pkg::MUX_W]))
      ##1 !addr_pin_oe_n_out)
    else $error("address pins not driven after strobe");
  a_addr_hiz: assert property (@(posedge core_clk_in) // RULE11
    disable iff (sys_rst_in)
    (cur.state == dsb_pkg::ST_IDLE && !cfg.en) |=> addr_pin_oe_n_out)
    else $error("address pins driven with controller off");
  a_burst_req: assert property (@(posedge core_clk_in) // RULE14
    disable iff (sys_rst_in)
    start && cfg.burst |=> !burst_request_n_out [*2])
    else $error("burst request missing");
  a_lane_cas: assert property (@(posedge core_clk_in) // RULE2
    disable iff (sys_rst_in)
    start && !cfg.two_we && !cfg.bus16 |=> ##1
      (~cur.stb.col_n == $past(access_be_in, 2)))
    else $error("column strobe lanes wrong");

  c_burst: cover property (@(posedge core_clk_in)
    cur.state == dsb_pkg::ST_CPRE);
  c_write: cover property (@(posedge core_clk_in)
    start && access_write_in);
  c_edo_read: cover property (@(posedge core_clk_in)
    !cur.stb.oe_n);

endmodule : dsb_strobe_lane

/* File: dv/dsb_dram_model.sv */
// Behavioural DRAM bank stub that answers each column phase with ready.
// Assumes the controller synchronises ready, so a one-cycle pulse suffices.
`timescale 1ns/1ps
module dsb_dram_model (
  input wire logic clk_in,         // Bus clock
  input wire logic rst_in,         // Reset, high
  input wire logic [3:0] col_n_in, // Column strobes, low
  input wire logic [3:0] delay_in, // Beat latency in cycles
  output logic ready_n_out         // Beat ready, low
);
  logic [3:0] cnt;  // Cycles spent in this column phase
  logic done;       // This beat already answered
  // One ready pulse per column phase, after a prompt or slow latency
  always @(posedge clk_in) begin
    ready_n_out <= 1'b1;
    if (rst_in || (&col_n_in)) begin
      cnt <= 4'h0;
      done <= 1'b0;
    end else if (!done && cnt >= delay_in) begin
      ready_n_out <= 1'b0;
      done <= 1'b1;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule : dsb_dram_model

/* File: dv/testbench.sv */
// Self-checking bench for the DRAM strobe and byte-lane output stage.
// Assumes the design package is compiled first and zero-wait APB.
`timescale 1ns/1ps
module testbench;
  typedef struct {
    logic [3:0] row, col, we;
    logic oe, bq;
    logic [11:0] ra, ca;
  } dsb_note_t;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, as_n = 1, awr = 0;
  logic perr, rdy_n;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, aaddr = 32'h0, rdata;
  logic [3:0] be = 4'h0, dly = 4'h0, prow = 4'hF, pcol = 4'hF;
  logic [11:0] ra;
  wire [31:0] prdata;
  wire pready, pslverr, oe, brq, aoe_n;
  wire [3:0] row, col, we;
  wire [11:0] apin;
  dsb_note_t q[$];
  dsb_note_t m;
  dsb_note_t n;                  // Note taken by the monitor
  logic [4:0] cfgs [4] = '{5'h01, 5'h09, 5'h05, 5'h03}; // Modes run
  int error_cnt = 0, check_count = 0;
  // -------------------------------------------------------------------
  // Design, DRAM stub and clock
  // -------------------------------------------------------------------
  dsb_strobe_lane u_dut (.core_clk_in(clk), .sys_rst_in(rst),
    .paddr_in(paddr), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .address_strobe_n_in(as_n),
    .access_addr_in(aaddr), .access_write_in(awr), .access_be_in(be),
    .ready_n_in(rdy_n), .row_strobe_bank0_n_out(row[0]),
    .row_strobe_bank1_n_out(row[1]), .row_strobe_bank2_n_out(row[2]),
    .row_strobe_bank3_n_out(row[3]), .column_strobe_lane0_n_out(col[0]),
    .column_strobe_lane1_n_out(col[1]), .column_strobe_lane2_n_out(col[2]),
    .column_strobe_lane3_n_out(col[3]), .mem_write_strobe_lane0_n_out(we[0]),
    .mem_write_strobe_lane1_n_out(we[1]),
    .mem_write_strobe_lane2_n_out(we[2]),
    .mem_write_strobe_lane3_n_out(we[3]), .mem_output_enable_n_out(oe),
    .burst_request_n_out(brq), .addr_pin_out(apin), .addr_pin_oe_n_out(aoe_n));
  dsb_dram_model u_mem (.clk_in(clk), .rst_in(rst), .col_n_in(col),
    .delay_in(dly), .ready_n_out(rdy_n));
  always #2.5 clk = ~clk;
  // -------------------------------------------------------------------
  // Shared tasks
  // -------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, exp, input string s);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s", $time, s);
    end
  endtask : check
  // One APB transfer: setup, then access until pready
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    paddr <= a;
    pwr <= w;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdata = prdata;
    perr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  // One DRAM access; notes the expected strobes of each beat
  task automatic access(input int b, input logic w, input logic [4:0] c);
    int t;
    logic [31:0] a;
    logic [3:0] e;
    a = {12'h100 + b[11:0], 20'($urandom())};
    e = 4'($urandom_range(1, 15)) | (c[3] ? 4'h4 : 4'h0);
    m.row = ~(4'h1 << b);
    m.col = c[2] ? 4'h0 : c[3] ? {~e[3], ~e[2], 2'b11} : ~e;
    m.we = !w ? 4'hF : c[2] ? ~e : 4'h0;
    m.oe = !(c[1] && !w);
    m.bq = !c[4];
    m.ra = a[25:14];
    for (int i = 0; i < (c[4] ? 4 : 1); i++) begin
      m.ca = a[13:2] + 12'(i);
      q.push_back(m);
    end
    @(posedge clk);
    aaddr <= a;
    be <= e;
    awr <= w;
    dly <= 4'($urandom_range(0, 5));
    as_n <= 1'b0;
    @(posedge clk);
    as_n <= 1'b1;
    #1 check(aoe_n, 1'b0, "pins not driven");
    t = 0;
    while ((q.size() != 0 || row != 4'hF) && t < 300) begin
      @(posedge clk);
      t++;
    end
    check(t < 300, 1'b1, "access hung");
    repeat (2) @(posedge clk);
  endtask : access
  task automatic complete_run();
    if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  // -------------------------------------------------------------------
  // Monitor: compares each column phase against the oldest note
  // -------------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst && (&row)) check(oe, 1'b1, "output enable idle");
    if ((&prow) && !(&row)) ra = apin;
    if (!rst && (&pcol) && !(&col)) begin
      if (q.size() == 0) begin
        check(1'b0, 1'b1, "unexpected column phase");
      end else begin
        n = q.pop_front();
        check(row, n.row, "row strobe");
        check(prow, n.row, "row not before column");
        check(col, n.col, "column strobes");
        check(we, n.we, "write strobes");
        check(oe, n.oe, "output enable");
        check(ra, n.ra, "row address");
        check(apin, n.ca, "column address");
        check(brq, n.bq, "burst request");
      end
    end
    prow = row;
    pcol = col;
  end
  // -------------------------------------------------------------------
  // Main sequence and watchdog
  // -------------------------------------------------------------------
  initial begin
    void'($urandom(5));
    repeat (5) @(posedge clk);
    #1 check({row, col, we, oe}, 13'h1FFF, "reset strobes");
    rst <= 1'b0;
    for (int b = 0; b < 4; b++)
      apb(dsb_pkg::BANK0_OFS + 8'(4 * b), 1'b1,
          {12'h100 + b[11:0], 4'h0, 12'hFFF, 3'h0, 1'b1});
    apb(8'h40, 1'b0, 32'h0);
    check(perr, 1'b1, "unmapped error");
    check(rdata, 32'h0, "unmapped read");
    // Fast page, 16-bit, 2-WE and EDO, each bank, read and write
    foreach (cfgs[k]) begin
      apb(dsb_pkg::CTRL_OFS, 1'b1, 32'(cfgs[k]));
      apb(dsb_pkg::CTRL_OFS, 1'b0, 32'h0);
      check(rdata[4:0], cfgs[k], "control readback");
      for (int b = 0; b < 4; b++) begin
        access(b, 1'b0, cfgs[k]);
        access(b, 1'b1, cfgs[k]);
      end
    end
    apb(dsb_pkg::CTRL_OFS, 1'b1, 32'h11);
    access(2, 1'b0, 5'h11);
    // Controller off: strobe must leave pins released and row strobes idle
    apb(dsb_pkg::CTRL_OFS, 1'b1, 32'h0);
    as_n <= 1'b0;
    repeat (4) @(posedge clk) check({row, aoe_n}, 5'h1F, "off");
    as_n <= 1'b1;
    complete_run();
  end
  initial begin
    #200000;
    error_cnt++;
    complete_run();
  end
endmodule : testbench
